// ===== core/patb_alpha_stage.sv
// patb_alpha_stage: per-pixel alpha test and alpha blend, APB registers.
// assumes: upstream presents source, unfogged and old destination pixel
// together for one cycle with pix_valid; downstream takes the result
// one cycle later with no back-pressure. pixels pack as A,R,G,B.
// limits: 8-bit math per lane with no dither; a factor of 0xFF is
// stretched to full scale so one times x returns x exactly.
// the reject counter wraps at its top; software clears it by a write.
//
// Functional notes
// RL1: alpha test compares source alpha with reference
// RL2: operator bits 3:1, source on left
// RL3: codes never,lt,eq,le,gt,ne,ge,always
// RL4: colour write needs pass and bit 9
// RL5: failed test: count, invalidate, no writes (out_valid stays set, out_rejected marks it)
// RL6: blend enable bit 4 mixes with destination
// RL7: colour = src*srcfactor + dst*dstfactor
// RL8: alpha = srcA*asrcfactor + dstA*adstfactor
// RL9: rgb factors at bits 11:8, 15:12
// RL10: alpha factors at 19:16, 23:20, independent
// RL11: factor codes zero..inverse dst alpha
// RL12: code 2 takes the other pixel colour
// RL13: source code 15 is min(sa, 1-da)
// RL14: destination code 15 is unfogged colour
// RL15: saturate results, one means full scale
`timescale 1ns/1ps
`default_nettype none

module patb_alpha_stage
    import patb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pix_valid,
    input wire logic [31:0] pix_src_argb,
    input wire logic [23:0] pix_unfogged_rgb,
    input wire logic [31:0] pix_dst_argb,
    output logic out_valid,
    output logic [31:0] out_argb,
    output logic out_colour_we,
    output logic out_depth_we,
    output logic out_rejected
);

    // ****************************************************************
    // blend factor selection
    // ****************************************************************
    // widen an 8-bit fraction so 0xFF becomes full scale 0x100
    function automatic logic [8:0] patb_scale(input logic [7:0] v);
        patb_scale = {1'b0, v} + {8'h00, v[7]};
    endfunction

    // factor for one lane; is_dst says which pixel is the other one.
    // reserved codes give zero, so a bad setting darkens, never wraps
    function automatic logic [8:0] patb_factor(
        input logic [3:0] code,
        input logic is_dst,
        input logic [7:0] s,
        input logic [7:0] d,
        input logic [7:0] sa,
        input logic [7:0] da,
        input logic [7:0] uf
    );
        logic [7:0] other;
        logic [7:0] inv_da;
        other = is_dst ? s : d;
        inv_da = PATB_MAX8 - da;
        unique case (code)
            factor_zero: patb_factor = 9'h000;
            factor_source_alpha: patb_factor = patb_scale(sa);
            // RL12: other pixel colour
            factor_other_colour: patb_factor = patb_scale(other);
            factor_destination_alpha: patb_factor = patb_scale(da);
            factor_one: patb_factor = PATB_FULL_SCALE;
            factor_inverse_source_alpha:
                patb_factor = patb_scale(PATB_MAX8 - sa);
            factor_inverse_other_colour:
                patb_factor = patb_scale(PATB_MAX8 - other);
            factor_inverse_destination_alpha:
                patb_factor = patb_scale(inv_da);
            factor_saturate_min: begin
                // RL14: destination side takes unfogged colour
                // RL13: source side takes the saturating minimum
                if (is_dst) begin
                    patb_factor = patb_scale(uf);
                end else begin
                    patb_factor = patb_scale((sa < inv_da) ? sa : inv_da);
                end
            end
            // RL11: reserved codes blend as zero
            default: patb_factor = 9'h000;
        endcase
    endfunction

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] bufctl_q, bufctl_d;
    logic [31:0] reject_q, reject_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic addr_ok;
    logic wr_fire;

    // ****************************************************************
    // pixel datapath
    // ****************************************************************
    logic [7:0] src_a;
    logic [7:0] dst_a;
    logic [7:0] ref_val;
    patb_op_t op;
    logic test_pass;
    logic test_fail;
    logic [31:0] blended;
    // out_*_q hold the result of the pixel taken one edge earlier
    logic out_valid_q, out_valid_d;
    logic [31:0] out_argb_q, out_argb_d;
    logic out_colour_we_q, out_colour_we_d;
    logic out_depth_we_q, out_depth_we_d;
    logic out_rejected_q, out_rejected_d;

    assign src_a = pix_src_argb[8*PATB_ALPHA_COMP +: 8];
    assign dst_a = pix_dst_argb[8*PATB_ALPHA_COMP +: 8];
    // RL1: reference sits in the top byte
    assign ref_val = ctrl_q[PATB_REF_LSB +: 8];
    // RL2: operator field
    assign op = patb_op_t'(ctrl_q[PATB_OP_LSB +: 3]);

    // the field is three bits, so every code is legal and needs no default
    // RL3: operator decode, source alpha on the left
    always_comb begin
        unique case (op)
            PATB_OP_NEVER: test_pass = 1'b0;
            PATB_OP_LT: test_pass = src_a < ref_val;
            PATB_OP_EQ: test_pass = src_a == ref_val;
            PATB_OP_LE: test_pass = src_a <= ref_val;
            PATB_OP_GT: test_pass = src_a > ref_val;
            PATB_OP_NE: test_pass = src_a != ref_val;
            PATB_OP_GE: test_pass = src_a >= ref_val;
            PATB_OP_ALWAYS: test_pass = 1'b1;
        endcase
    end

    // a disabled test never rejects, whatever the operator says
    // RL1: test only counts while enabled
    assign test_fail = pix_valid && ctrl_q[PATB_TEST_EN_BIT] && !test_pass;

    // the four lanes share one shape; only the field picks and the unfogged input differ
    // per component blend: components 0..2 are B,G,R, 3 is alpha
    generate
        for (genvar i = 0; i < PATB_NCOMP; i++) begin : g_comp
            localparam bit IS_A = (i == PATB_ALPHA_COMP);
            logic [3:0] sf_code;
            logic [3:0] df_code;
            logic [7:0] s_c;
            logic [7:0] d_c;
            logic [7:0] uf_c;
            logic [8:0] sf;
            logic [8:0] df;
            logic [16:0] sp;
            logic [16:0] dp;
            logic [9:0] sum;
            // RL9: rgb factor fields
            // RL10: alpha channel factor fields
            assign sf_code = IS_A ? ctrl_q[PATB_A_SRC_LSB +: 4]
                                  : ctrl_q[PATB_RGB_SRC_LSB +: 4];
            assign df_code = IS_A ? ctrl_q[PATB_A_DST_LSB +: 4]
                                  : ctrl_q[PATB_RGB_DST_LSB +: 4];
            assign s_c = pix_src_argb[8*i +: 8];
            assign d_c = pix_dst_argb[8*i +: 8];
            // alpha has no unfogged copy, the source alpha stands in
            assign uf_c = IS_A ? src_a : pix_unfogged_rgb[8*(i % 3) +: 8];
            assign sf = patb_factor(sf_code, 1'b0, s_c, d_c, src_a, dst_a,
                                    uf_c);
            assign df = patb_factor(df_code, 1'b1, s_c, d_c, src_a, dst_a,
                                    uf_c);
            // 255 times full scale still fits the 17-bit products
            // RL7: source term plus destination term
            // RL8: same form on the alpha channel
            assign sp = {9'h000, s_c} * {8'h00, sf};
            assign dp = {9'h000, d_c} * {8'h00, df};
            assign sum = {1'b0, sp[16:8]} + {1'b0, dp[16:8]};
            // a sum reaches 510 at most; anything past 255 is clamped
            // RL15: clamp instead of wrapping
            assign blended[8*i +: 8] = (sum > {2'b00, PATB_MAX8}) ?
                                       PATB_MAX8 : sum[7:0];
        end
    endgenerate

    // output stage next values; a rejected pixel keeps out_valid so
    // the pipe downstream stays in step with upstream
    always_comb begin
        out_valid_d = pix_valid;
        out_rejected_d = test_fail;
        // RL6: blend only while enabled, else pass the source through
        out_argb_d = ctrl_q[PATB_BLEND_EN_BIT] ? blended : pix_src_argb;
        // RL4: colour write needs a pass and the enable bit
        out_colour_we_d = pix_valid && !test_fail &&
                          bufctl_q[PATB_COLOUR_WE_BIT];
        // RL5: failed pixel writes no depth either
        out_depth_we_d = pix_valid && !test_fail &&
                         bufctl_q[PATB_DEPTH_WE_BIT];
    end

    // pixel output registers
    // upstream never waits, so there is no stall path to register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_q <= 1'b0;
            out_argb_q <= PATB_ZERO32;
            out_colour_we_q <= 1'b0;
            out_depth_we_q <= 1'b0;
            out_rejected_q <= 1'b0;
        end else begin
            out_valid_q <= out_valid_d;
            out_argb_q <= out_argb_d;
            out_colour_we_q <= out_colour_we_d;
            out_depth_we_q <= out_depth_we_d;
            out_rejected_q <= out_rejected_d;
        end
    end

    // ****************************************************************
    // apb slave
    // ****************************************************************
    // three mapped words; addr_ok also keeps stray writes from landing
    assign addr_ok = (paddr == PATB_OFS_CTRL) || (paddr == PATB_OFS_BUFCTL)
                     || (paddr == PATB_OFS_REJECT);
    assign wr_fire = psel && penable && pready_q && pwrite && addr_ok;

    // no wait state: data and ready are loaded from the setup cycle,
    // which keeps prdata straight from a flop
    always_comb begin
        pready_d = psel && !penable && !pready_q;
        pslverr_d = psel && !penable && !pready_q && !addr_ok;
        prdata_d = PATB_ZERO32;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                PATB_OFS_CTRL: prdata_d = ctrl_q;
                PATB_OFS_BUFCTL: prdata_d = bufctl_q;
                PATB_OFS_REJECT: prdata_d = reject_q;
                default: prdata_d = PATB_ZERO32;
            endcase
        end
        // writes land on the access edge, when pready is already high
        ctrl_d = ctrl_q;
        bufctl_d = bufctl_q;
        if (wr_fire && paddr == PATB_OFS_CTRL) begin
            ctrl_d = pwdata;
        end
        if (wr_fire && paddr == PATB_OFS_BUFCTL) begin
            bufctl_d = pwdata;
        end
        // RL5: count rejects; a reject in the clearing cycle survives
        reject_d = reject_q;
        if (wr_fire && paddr == PATB_OFS_REJECT) begin
            reject_d = test_fail ? PATB_ONE32 : PATB_ZERO32;
        end else if (test_fail) begin
            reject_d = reject_q + PATB_ONE32;
        end
    end

    // register file and bus answer
    // bus answer from flops so prdata never glitches with the decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= PATB_CTRL_RST;
            bufctl_q <= PATB_BUFCTL_RST;
            reject_q <= PATB_ZERO32;
            prdata_q <= PATB_ZERO32;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            bufctl_q <= bufctl_d;
            reject_q <= reject_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // every output straight from its flop
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign out_valid = out_valid_q;
    assign out_argb = out_argb_q;
    assign out_colour_we = out_colour_we_q;
    assign out_depth_we = out_depth_we_q;
    assign out_rejected = out_rejected_q;

endmodule

`default_nettype wire

// ===== core/patb_pkg.sv
// patb_pkg: constants for the alpha test and blend stage.
// assumes: 32-bit APB register bus, one aligned word per register.
package patb_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] PATB_OFS_CTRL = 8'h00;
    localparam logic [7:0] PATB_OFS_BUFCTL = 8'h04;
    localparam logic [7:0] PATB_OFS_REJECT = 8'h08;
    localparam logic [31:0] PATB_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] PATB_BUFCTL_RST = 32'h0000_0000;
    localparam logic [31:0] PATB_ZERO32 = 32'h0000_0000;
    localparam logic [31:0] PATB_ONE32 = 32'h0000_0001;

    // ****************************************************************
    // field positions in alpha_test_blend_control
    // ****************************************************************
    localparam int PATB_TEST_EN_BIT = 0;
    localparam int PATB_OP_LSB = 1;
    localparam int PATB_BLEND_EN_BIT = 4;
    localparam int PATB_RGB_SRC_LSB = 8;
    localparam int PATB_RGB_DST_LSB = 12;
    localparam int PATB_A_SRC_LSB = 16;
    localparam int PATB_A_DST_LSB = 20;
    localparam int PATB_REF_LSB = 24;
    // buffer_write_control bits
    localparam int PATB_COLOUR_WE_BIT = 9;
    localparam int PATB_DEPTH_WE_BIT = 10;

    // ****************************************************************
    // compare operators and blend factor codes
    // ****************************************************************
    typedef enum logic [2:0] {
        PATB_OP_NEVER = 3'h0,
        PATB_OP_LT = 3'h1,
        PATB_OP_EQ = 3'h2,
        PATB_OP_LE = 3'h3,
        PATB_OP_GT = 3'h4,
        PATB_OP_NE = 3'h5,
        PATB_OP_GE = 3'h6,
        PATB_OP_ALWAYS = 3'h7
    } patb_op_t;

    localparam logic [3:0] factor_zero = 4'h0;
    localparam logic [3:0] factor_source_alpha = 4'h1;
    localparam logic [3:0] factor_other_colour = 4'h2;
    localparam logic [3:0] factor_destination_alpha = 4'h3;
    localparam logic [3:0] factor_one = 4'h4;
    localparam logic [3:0] factor_inverse_source_alpha = 4'h5;
    localparam logic [3:0] factor_inverse_other_colour = 4'h6;
    localparam logic [3:0] factor_inverse_destination_alpha = 4'h7;
    localparam logic [3:0] factor_saturate_min = 4'hF;
    // same code as the saturate one, seen from the destination side
    localparam logic [3:0] factor_unfogged_colour = 4'hF;

    // full scale factor: one is 256 so a product >> 8 is exact
    localparam logic [8:0] PATB_FULL_SCALE = 9'h100;
    localparam logic [7:0] PATB_MAX8 = 8'hFF;
    localparam int PATB_NCOMP = 4;
    localparam int PATB_ALPHA_COMP = 3;

endpackage

// ===== bench/patb_alpha_stage_monitor.sv
// checker for the alpha stage: apb answer timing and pixel flags.
// assumes: bound to patb_alpha_stage, one pclk domain.
`timescale 1ns/1ps
`default_nettype none
module patb_alpha_stage_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pix_valid,
    input wire logic out_valid,
    input wire logic out_colour_we,
    input wire logic out_depth_we,
    input wire logic out_rejected
);
    // ****************************************************************
    // port properties
    // ****************************************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic setup = psel && !penable;

    // apb: one wait-free access, unmapped space refused
    apb_answer_a: assert property (setup |=> pready ##1 !pready)
        else $error("pready not a one cycle answer");
    unmapped_err_a: assert property (setup && !pwrite && paddr > 8'h08
        |=> pslverr && pready && prdata == 32'h0)
        else $error("unmapped read not refused");
    mapped_ok_a: assert property (setup && (paddr == 8'h00
        || paddr == 8'h04 || paddr == 8'h08) |=> !pslverr)
        else $error("mapped access refused");
    reset_quiet_a: assert property ($rose(presetn) |-> !out_valid && !pready)
        else $error("outputs busy after reset");
    // pixel flags stay tied to the pixel that caused them
    pix_latency_a: assert property (pix_valid |=> out_valid)
        else $error("pixel result missing");
    out_cause_a: assert property (out_valid |-> $past(pix_valid))
        else $error("result without a pixel");
    reject_nowrite_a: assert property (out_rejected |->
        out_valid && !out_colour_we && !out_depth_we)
        else $error("rejected pixel still written");
    write_valid_a: assert property ((out_colour_we || out_depth_we)
        |-> out_valid && !out_rejected)
        else $error("write without passing pixel");
    cover property (out_rejected);
    cover property (out_colour_we && !out_depth_we);
    cover property (setup && paddr > 8'h08 ##1 pslverr);
endmodule
bind patb_alpha_stage patb_alpha_stage_monitor mon_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_valid(pix_valid), .out_valid(out_valid),
    .out_colour_we(out_colour_we), .out_depth_we(out_depth_we),
    .out_rejected(out_rejected));
`default_nettype wire

// ===== bench/patb_pixel_feed.sv
// pixel feed: stands in for the upstream pipe and frame buffer read.
// assumes: the bench calls send, one pixel per call.
`timescale 1ns/1ps
`default_nettype none
module patb_pixel_feed (
    input wire logic pclk,
    output var logic pix_valid,
    output var logic [31:0] pix_src_argb,
    output var logic [23:0] pix_unfogged_rgb,
    output var logic [31:0] pix_dst_argb
);
    // idle until the first pixel
    initial begin
        pix_valid = 1'b0;
        pix_src_argb = '0;
        pix_unfogged_rgb = '0;
        pix_dst_argb = '0;
    end
    task automatic send(input logic [31:0] s, input logic [23:0] u,
            input logic [31:0] d);
        @(posedge pclk);
        pix_valid <= 1'b1;
        pix_src_argb <= s;
        pix_unfogged_rgb <= u;
        pix_dst_argb <= d;
        @(posedge pclk);
        pix_valid <= 1'b0;
        // stale lines scrambled so nothing leans on old data
        pix_src_argb <= ~s;
        pix_unfogged_rgb <= ~u;
        pix_dst_argb <= ~d;
    endtask
endmodule
`default_nettype wire

// ===== bench/patb_alpha_stage_test.sv
// bench for the alpha stage: apb master, pixel feed, reference math.
// assumes: pclk 25 MHz, one cycle pixel latency.
`timescale 1ns/1ps
`default_nettype none
module patb_alpha_stage_test;
    import patb_pkg::*;
    // pm: expected pass per operator code, bit n for code n, ref 0x80
    typedef struct packed {
        logic [31:0] s;
        logic [23:0] u;
        logic [31:0] d;
        logic [7:0] pm;
    } patb_row_t;
    patb_row_t rows [4] = '{
        '{32'h80_40_C0_FF, 24'h20_30_40, 32'h7F_FF_10_80, 8'hCC},
        '{32'h7F_12_34_56, 24'hFF_00_80, 32'hFF_80_80_80, 8'hAA},
        '{32'h81_FF_FF_FF, 24'h01_02_03, 32'h00_FF_FF_FF, 8'hF0},
        '{32'hFF_00_01_02, 24'hA5_5A_C3, 32'h80_C0_E0_F0, 8'hF0}};
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, pix_valid;
    logic out_valid, out_colour_we, out_depth_we, out_rejected, erv, rej;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, pix_src_argb, pix_dst_argb, out_argb;
    logic [31:0] rdv, ctl, nrej;
    logic [23:0] pix_unfogged_rgb;
    logic [3:0] c;
    int miscompares = 0;
    int samples_checked = 0;

    always #20 pclk = ~pclk;
    patb_alpha_stage dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pix_valid(pix_valid), .pix_src_argb(pix_src_argb),
        .pix_unfogged_rgb(pix_unfogged_rgb), .pix_dst_argb(pix_dst_argb),
        .out_valid(out_valid), .out_argb(out_argb),
        .out_colour_we(out_colour_we), .out_depth_we(out_depth_we),
        .out_rejected(out_rejected));
    patb_pixel_feed feed_u (.pclk(pclk), .pix_valid(pix_valid),
        .pix_src_argb(pix_src_argb), .pix_unfogged_rgb(pix_unfogged_rgb),
        .pix_dst_argb(pix_dst_argb));

    // ****************************************************************
    // compare, bus and reference helpers
    // ****************************************************************
    task automatic chk(input string n, input logic [31:0] e,
            input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        chk(n, {31'h0, e}, {31'h0, g});
    endtask
    // request held until the edge that samples pready high; the answer
    // is taken at that edge and only then is the request released
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // factor codes, reserved act as zero
    function automatic int fac(input logic [3:0] code, input bit dst,
            input int s, input int d, input int sa, input int da, input int u);
        int f;
        case (code)
            4'h1: f = sa;
            4'h2: f = dst ? s : d;
            4'h3: f = da;
            4'h4: f = 255;
            4'h5: f = 255 - sa;
            4'h6: f = 255 - (dst ? s : d);
            4'h7: f = 255 - da;
            4'hF: f = dst ? u : (sa < 255 - da ? sa : 255 - da);
            default: f = 0;
        endcase
        // 255 stretched to 256 so factor one is full scale
        return f + (f >= 128 ? 1 : 0);
    endfunction
    function automatic logic [31:0] ref_pix(input logic [31:0] c,
            input logic [31:0] s, input logic [23:0] u, input logic [31:0] d);
        logic [31:0] r;
        logic [31:0] ux;
        int k, t;
        r = s;
        ux = {s[31:24], u};
        for (k = 0; k < 4; k++) begin
            t = ((s[8*k+:8] * fac(k == 3 ? c[19:16] : c[11:8], 0, s[8*k+:8],
                d[8*k+:8], s[31:24], d[31:24], ux[8*k+:8])) >> 8)
                + ((d[8*k+:8] * fac(k == 3 ? c[23:20] : c[15:12], 1,
                s[8*k+:8], d[8*k+:8], s[31:24], d[31:24], ux[8*k+:8])) >> 8);
            if (c[4]) r[8*k+:8] = t > 255 ? 8'hFF : t[7:0];
        end
        return r;
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog well past the few hundred cycles the run needs
    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        tally_and_finish();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        nrej = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, PATB_OFS_CTRL, 0);
        chk("ctrl reset", PATB_CTRL_RST, rdv);
        apb(1'b0, PATB_OFS_REJECT, 0);
        chk("count reset", PATB_ZERO32, rdv);
        apb(1'b1, PATB_OFS_BUFCTL, 32'h0000_0600);
        // every op, every factor code on both sides of both channels,
        // alpha fields crossed against rgb; first half blends, second
        // half passes the source through
        for (int k = 0; k < 32; k++) begin
            c = k[3:0];
            ctl = {8'h80, c, ~c, ~c, c, 3'h0, ~k[4], c[2:0], c[3]};
            apb(1'b1, PATB_OFS_CTRL, ctl);
            for (int j = 0; j < 4; j++) begin
                feed_u.send(rows[j].s, rows[j].u, rows[j].d);
                #1;
                rej = c[3] && !rows[j].pm[c[2:0]];
                nrej = nrej + {31'h0, rej};
                chk_bit("out_valid", 1'b1, out_valid);
                chk_bit("out_rejected", rej, out_rejected);
                chk_bit("out_colour_we", !rej, out_colour_we);
                chk_bit("out_depth_we", !rej, out_depth_we);
                if (!rej) chk("out_argb", ref_pix(ctl, rows[j].s,
                    rows[j].u, rows[j].d), out_argb);
            end
        end
        apb(1'b0, PATB_OFS_REJECT, 0);
        chk("reject count", nrej, rdv);
        apb(1'b1, PATB_OFS_REJECT, 0);
        apb(1'b0, PATB_OFS_REJECT, 0);
        chk("cleared count", PATB_ZERO32, rdv);
        // passing pixel with colour writes masked off
        apb(1'b1, PATB_OFS_BUFCTL, 32'h0000_0400);
        apb(1'b1, PATB_OFS_CTRL, 32'h0000_000F);
        feed_u.send(rows[1].s, rows[1].u, rows[1].d);
        #1;
        chk_bit("out_colour_we", 1'b0, out_colour_we);
        chk_bit("out_depth_we", 1'b1, out_depth_we);
        chk("out_argb", rows[1].s, out_argb);
        // unmapped space refused and harmless
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        chk_bit("pslverr", 1'b1, erv);
        apb(1'b0, 8'h0C, 0);
        chk_bit("pslverr", 1'b1, erv);
        chk("prdata", PATB_ZERO32, rdv);
        apb(1'b0, PATB_OFS_CTRL, 0);
        chk("ctrl kept", 32'h0000_000F, rdv);
        // reject on the very edge that clears the counter: it survives
        apb(1'b1, PATB_OFS_CTRL, 32'h0000_0001);
        feed_u.send(rows[0].s, rows[0].u, rows[0].d);
        fork
            apb(1'b1, PATB_OFS_REJECT, 0);
            begin
                @(posedge pclk);
                feed_u.send(rows[0].s, rows[0].u, rows[0].d);
            end
        join
        apb(1'b0, PATB_OFS_REJECT, 0);
        chk("clear with reject", PATB_ONE32, rdv);
        // second reset in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, PATB_OFS_CTRL, 0);
        chk("ctrl re-reset", PATB_CTRL_RST, rdv);
        apb(1'b0, PATB_OFS_REJECT, 0);
        chk("count re-reset", PATB_ZERO32, rdv);
        tally_and_finish();
    end
endmodule
`default_nettype wire
